/* design/lms_status.sv */
// Line maintenance status bits with code qualification, clock loss watch and interrupts
//
// Function
// - Loop-up bit sets after qualified error-free code
// - Qualify 40 ms, or 5.1 s when automatic
// - Loop-up rising edge starts remote loopback
// - Loop-down bit sets after qualified error-free code
// - Loop-down rising edge ends remote loopback
// - Loop-up interrupt: rising edge or any change
// - Loop-down interrupt: rising edge or any change
// - Pattern lock bit follows receiver sync live
// - Pattern lock interrupt: rising edge or any
// - Clock loss after 70 quiet master cycles
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "lms_regs.svh"

module lms_status #(
  parameter int unsigned SHORT_QUAL_CYCLES = `LMS_QUAL_SHORT_MS * `LMS_CLK_KHZ, // 40 ms
  parameter int unsigned LONG_QUAL_CYCLES  = `LMS_QUAL_LONG_MS * `LMS_CLK_KHZ   // 5.1 s
) (
  input  wire logic                   sys_clk,              // Master clock, 200 MHz
  input  wire logic                   sys_rst,              // Asynchronous reset, active high
  input  wire logic [`LMS_ADDR_W-1:0] reg_addr,             // Register address
  input  wire logic [`LMS_DATA_W-1:0] reg_wr_data,          // Register write data
  input  wire logic                   reg_wr_en,            // Write strobe
  input  wire logic                   reg_rd_en,            // Read strobe
  output logic      [`LMS_DATA_W-1:0] reg_rd_data,          // Read data, cycle after strobe
  input  wire logic                   loop_up_code_seen,    // Loop-up code being received
  input  wire logic                   loop_up_ber_ok,       // Loop-up code error rate below 1 %
  input  wire logic                   loop_down_code_seen,  // Loop-down code being received
  input  wire logic                   loop_down_ber_ok,     // Loop-down code error rate below 1 %
  input  wire logic                   pattern_sync,         // Receiver locked to test pattern
  input  wire logic                   transmit_clock_input, // Transmit clock pin, asynchronous
  output logic                        remote_loop_active,   // Remote loopback running
  output logic                        irq                   // Interrupt, level, active high
);

  // -------------------------------------------------------------------------
  // Address decode, shared by the write and read paths
  // -------------------------------------------------------------------------
  function automatic logic lms_hit(input logic [`LMS_ADDR_W-1:0] addr,
                                   input logic [`LMS_ADDR_W-1:0] offset);
    lms_hit = (addr == offset);
  endfunction : lms_hit

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  lms_pkg::lms_state_type st;        // Registered state
  lms_pkg::lms_state_type next_st;   // Next state

  logic [1:0] code_seen;             // Code present, index 1 up, 0 down
  logic [1:0] code_ok;               // Error rate in limit, same indexing
  logic [`LMS_QUAL_W-1:0] qual_limit; // Active qualification length
  logic [`LMS_NUM_BITS-1:0] change;  // Status bits that move this cycle
  logic [`LMS_NUM_BITS-1:0] event_v; // Interrupt events this cycle
  logic transmit_clock_input_edge;                   // Transition seen on the transmit clock
  logic up_rise;                     // Loop-up status about to rise
  logic down_rise;                   // Loop-down status about to rise
  logic [`LMS_DATA_W-1:0] rd_mux;    // Selected read value

  assign code_seen = {loop_up_code_seen, loop_down_code_seen};
  assign code_ok   = {loop_up_ber_ok, loop_down_ber_ok};

  // -------------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    // Pin synchroniser; only the second stage and beyond are looked at
    next_st.transmit_clock_input_sync = {st.transmit_clock_input_sync[0], transmit_clock_input};
    next_st.transmit_clock_input_last = st.transmit_clock_input_sync[1];
    transmit_clock_input_edge         = st.transmit_clock_input_sync[1] ^ st.transmit_clock_input_last;

    // Quiet-cycle counter saturates just above the limit
    if (transmit_clock_input_edge)
    begin
      next_st.idle_cnt = '0;
    end
    else if (st.idle_cnt <= `LMS_TRANSMIT_CLOCK_INPUT_LIMIT)
    begin
      next_st.idle_cnt = st.idle_cnt + 7'h01;
    end
    // Loss once more than the limit has passed with no transition
    next_st.status[`LMS_IDX_TXL] = (next_st.idle_cnt > `LMS_TRANSMIT_CLOCK_INPUT_LIMIT);

    // Pattern lock is a live copy of the receiver sync flag
    next_st.status[`LMS_IDX_PAT] = pattern_sync;

    // Qualification length follows the automatic switching bit
    qual_limit = st.auto_loop ? LONG_QUAL_CYCLES[`LMS_QUAL_W-1:0]
                              : SHORT_QUAL_CYCLES[`LMS_QUAL_W-1:0];

    // Loop-up and loop-down detectors share one structure
    for (int i = 0; i < 2; i++)
    begin
      if (st.status[i+2])
      begin
        // Held while the error rate stays in limit, dropped at once otherwise
        if (!code_ok[i])
        begin
          next_st.status[i+2] = 1'b0;
          next_st.qual_cnt[i] = '0;
        end
      end
      else if (code_seen[i] && code_ok[i])
      begin
        // Count clean code time; set once the count has covered t
        if (st.qual_cnt[i] >= qual_limit)
        begin
          next_st.status[i+2] = 1'b1;
        end
        else
        begin
          next_st.qual_cnt[i] = st.qual_cnt[i] + 30'h1;
        end
      end
      else
      begin
        // Any break restarts the qualification
        next_st.qual_cnt[i] = '0;
      end
    end

    // Remote loopback: start on loop-up rise, end on loop-down rise.
    // A loop-down rise in the same cycle wins, so the link is never left looped.
    up_rise   = next_st.status[`LMS_IDX_UP] & ~st.status[`LMS_IDX_UP];
    down_rise = next_st.status[`LMS_IDX_DOWN] & ~st.status[`LMS_IDX_DOWN];
    if (down_rise)
    begin
      next_st.remote_loop = 1'b0;
    end
    else if (up_rise)
    begin
      next_st.remote_loop = 1'b1;
    end

    // Interrupt events: rising edge, or any change when the edge bit is set
    change  = next_st.status ^ st.status;
    event_v = change & (st.any_edge | next_st.status);

    // Read of the sticky register clears it; a new event still wins
    if (reg_rd_en && lms_hit(reg_addr, `LMS_REG_STICKY))
    begin
      next_st.sticky = event_v;
    end
    else
    begin
      next_st.sticky = st.sticky | event_v;
    end

    // Register writes
    if (reg_wr_en)
    begin
      if (lms_hit(reg_addr, `LMS_REG_MASK))
      begin
        next_st.mask = reg_wr_data[`LMS_FLD_MSB:`LMS_FLD_LSB];
      end
      if (lms_hit(reg_addr, `LMS_REG_EDGE))
      begin
        next_st.any_edge = reg_wr_data[`LMS_FLD_MSB:`LMS_FLD_LSB];
      end
      if (lms_hit(reg_addr, `LMS_REG_CTRL))
      begin
        next_st.auto_loop = reg_wr_data[`LMS_CTRL_AUTO];
      end
    end

    // Masked bits still latch but never reach the pin
    next_st.irq = |(next_st.sticky & ~next_st.mask);

    // Read path; unmapped offsets and idle cycles read zero
    rd_mux = '0;
    if (lms_hit(reg_addr, `LMS_REG_LIVE))
    begin
      rd_mux[`LMS_FLD_MSB:`LMS_FLD_LSB] = st.status;
    end
    else if (lms_hit(reg_addr, `LMS_REG_STICKY))
    begin
      rd_mux[`LMS_FLD_MSB:`LMS_FLD_LSB] = st.sticky;
    end
    else if (lms_hit(reg_addr, `LMS_REG_MASK))
    begin
      rd_mux[`LMS_FLD_MSB:`LMS_FLD_LSB] = st.mask;
    end
    else if (lms_hit(reg_addr, `LMS_REG_EDGE))
    begin
      rd_mux[`LMS_FLD_MSB:`LMS_FLD_LSB] = st.any_edge;
    end
    else if (lms_hit(reg_addr, `LMS_REG_CTRL))
    begin
      rd_mux[`LMS_CTRL_AUTO] = st.auto_loop;
    end
    next_st.rd_data = reg_rd_en ? rd_mux : '0;
  end

  // -------------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st          <= '0;
      st.mask     <= `LMS_MASK_RST;
      st.any_edge <= `LMS_EDGE_RST;
      st.status   <= `LMS_STAT_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign reg_rd_data        = st.rd_data;
  assign remote_loop_active = st.remote_loop;
  assign irq                = st.irq;

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  // Read strobe aimed at the sticky register, watched by the read-clear checks
  logic sticky_rd;                   // Sticky register read this cycle
  assign sticky_rd = reg_rd_en & lms_hit(reg_addr, `LMS_REG_STICKY);

  // All checks share the master clock and rest while reset is held
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Loss only rises after exactly the tolerated quiet count
  a_tx_loss_rise: assert property ($rose(st.status[`LMS_IDX_TXL]) |->
      (st.idle_cnt == (`LMS_TRANSMIT_CLOCK_INPUT_LIMIT + 7'h01)) &&
      ($past(st.transmit_clock_input_sync[1]) == $past(st.transmit_clock_input_last)))
    else $error("transmit clock loss set at wrong count");

  // Loss stays low while the quiet count is within the limit
  a_tx_loss_early: assert property ((st.idle_cnt <= `LMS_TRANSMIT_CLOCK_INPUT_LIMIT) |->
      !st.status[`LMS_IDX_TXL])
    else $error("transmit clock loss set too early");

  // A synchronised pin transition clears the loss on the next edge
  a_tx_loss_clear: assert property ((st.transmit_clock_input_sync[1] != st.transmit_clock_input_last) |=>
      !st.status[`LMS_IDX_TXL])
    else $error("transmit clock loss not cleared by a transition");

  // Loop-up may rise only after the counter covered the active length
  a_loop_up_qual: assert property ($rose(st.status[`LMS_IDX_UP]) |->
      $past(st.qual_cnt[1]) >= ($past(st.auto_loop) ?
      LONG_QUAL_CYCLES[`LMS_QUAL_W-1:0] : SHORT_QUAL_CYCLES[`LMS_QUAL_W-1:0]))
    else $error("loop-up status set before qualification");

  // Loop-down may rise only after the counter covered the active length
  a_loop_down_qual: assert property ($rose(st.status[`LMS_IDX_DOWN]) |->
      $past(st.qual_cnt[0]) >= ($past(st.auto_loop) ?
      LONG_QUAL_CYCLES[`LMS_QUAL_W-1:0] : SHORT_QUAL_CYCLES[`LMS_QUAL_W-1:0]))
    else $error("loop-down status set before qualification");

  // Loop-up rises only on a cycle of clean code
  a_up_needs_code: assert property ($rose(st.status[`LMS_IDX_UP]) |->
      $past(loop_up_code_seen) && $past(loop_up_ber_ok))
    else $error("loop-up status set without clean code");

  // Loop-down rises only on a cycle of clean code
  a_down_needs_code: assert property ($rose(st.status[`LMS_IDX_DOWN]) |->
      $past(loop_down_code_seen) && $past(loop_down_ber_ok))
    else $error("loop-down status set without clean code");

  // A bad error rate drops the loop-up bit on the next edge
  a_loop_up_drop: assert property (!loop_up_ber_ok |=> !st.status[`LMS_IDX_UP])
    else $error("loop-up status held with bad error rate");

  // A bad error rate drops the loop-down bit on the next edge
  a_loop_down_drop: assert property (!loop_down_ber_ok |=> !st.status[`LMS_IDX_DOWN])
    else $error("loop-down status held with bad error rate");

  // Loop-up rise without loop-down rise starts the remote loop
  a_remote_start: assert property ($rose(st.status[`LMS_IDX_UP]) &&
      !$rose(st.status[`LMS_IDX_DOWN]) |-> remote_loop_active)
    else $error("remote loop not started");

  // Loop-down rise always ends the remote loop
  a_remote_stop: assert property ($rose(st.status[`LMS_IDX_DOWN]) |->
      !remote_loop_active)
    else $error("remote loop not ended");

  // A loop-up rise latches its event
  a_up_latched: assert property ($rose(st.status[`LMS_IDX_UP]) |->
      st.sticky[`LMS_IDX_UP])
    else $error("loop-up rise not latched");

  // A loop-down rise latches its event
  a_down_latched: assert property ($rose(st.status[`LMS_IDX_DOWN]) |->
      st.sticky[`LMS_IDX_DOWN])
    else $error("loop-down rise not latched");

  // A pattern lock rise latches its event
  a_rise_latched: assert property ($rose(st.status[`LMS_IDX_PAT]) |->
      st.sticky[`LMS_IDX_PAT])
    else $error("pattern lock rise not latched");

  // A clock-loss rise latches its event
  a_txl_latched: assert property ($rose(st.status[`LMS_IDX_TXL]) |->
      st.sticky[`LMS_IDX_TXL])
    else $error("clock loss rise not latched");

  // In rising-edge mode a fall latches nothing new
  a_fall_ignored: assert property ($fell(st.status[`LMS_IDX_UP]) &&
      !$past(st.any_edge[`LMS_IDX_UP]) && !$past(st.sticky[`LMS_IDX_UP]) |->
      !st.sticky[`LMS_IDX_UP])
    else $error("fall latched in rising-edge mode");

  // In any-change mode a fall is latched too
  a_fall_any_edge: assert property ($fell(st.status[`LMS_IDX_DOWN]) &&
      $past(st.any_edge[`LMS_IDX_DOWN]) |-> st.sticky[`LMS_IDX_DOWN])
    else $error("fall missed in any-change mode");

  // In any-change mode a pattern lock fall is latched
  a_pat_any_fall: assert property ($fell(st.status[`LMS_IDX_PAT]) &&
      $past(st.any_edge[`LMS_IDX_PAT]) |-> st.sticky[`LMS_IDX_PAT])
    else $error("pattern lock fall missed in any-change mode");

  // In any-change mode a clock-loss fall is latched
  a_txl_any_fall: assert property ($fell(st.status[`LMS_IDX_TXL]) &&
      $past(st.any_edge[`LMS_IDX_TXL]) |-> st.sticky[`LMS_IDX_TXL])
    else $error("clock loss fall missed in any-change mode");

  // Fully masked events never raise the pin
  a_mask_blocks: assert property ((st.mask == {`LMS_NUM_BITS{1'b1}}) |-> !irq)
    else $error("interrupt raised while masked");

  // The pin is high only for a latched, unmasked event
  a_irq_cause: assert property (irq |->
      ((st.sticky & ~st.mask) != '0))
    else $error("interrupt raised with no unmasked event");

  // An unmasked clock-loss event raises the pin
  a_txl_irq: assert property (st.sticky[`LMS_IDX_TXL] &&
      !st.mask[`LMS_IDX_TXL] |-> irq)
    else $error("clock loss interrupt missing");

  // A sticky read returns the events held before the read
  a_sticky_data: assert property ($past(sticky_rd) |->
      (reg_rd_data[`LMS_FLD_MSB:`LMS_FLD_LSB] == $past(st.sticky)))
    else $error("sticky read returned wrong events");

  // A sticky read clears all but the events of the read cycle
  a_sticky_clear: assert property ($past(sticky_rd) |->
      (st.sticky == $past(event_v)))
    else $error("sticky read did not clear");

  // Pattern lock follows the receiver one cycle late
  a_pattern_live: assert property (##1 st.status[`LMS_IDX_PAT] == $past(pattern_sync))
    else $error("pattern lock not live");

endmodule : lms_status

/* design/lms_regs.svh */
// Register offsets, field positions, reset values and timing constants of the line status block
`ifndef LMS_REGS_SVH
`define LMS_REGS_SVH

// ---------------------------------------------------------------------------
// Register port geometry
// ---------------------------------------------------------------------------
`define LMS_ADDR_W        3
`define LMS_DATA_W        8

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define LMS_REG_LIVE      3'h0   // Live status bits, read only
`define LMS_REG_STICKY    3'h1   // Sticky event bits, cleared by a read
`define LMS_REG_MASK      3'h2   // Interrupt masks, one suppresses
`define LMS_REG_EDGE      3'h3   // Edge select, one means any change
`define LMS_REG_CTRL      3'h4   // Control bits

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define LMS_FLD_LSB       3      // Lowest status bit in a register byte
`define LMS_FLD_MSB       6      // Highest status bit in a register byte
`define LMS_NUM_BITS      4      // Status bits held
`define LMS_IDX_UP        2'h3   // Loop-up code status, byte bit 6
`define LMS_IDX_DOWN      2'h2   // Loop-down code status, byte bit 5
`define LMS_IDX_PAT       2'h1   // Pattern lock status, byte bit 4
`define LMS_IDX_TXL       2'h0   // Transmit clock loss, byte bit 3
`define LMS_CTRL_AUTO     0      // Automatic remote loop switching enable

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define LMS_MASK_RST      4'hf
`define LMS_EDGE_RST      4'h0
`define LMS_STAT_RST      4'h0

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define LMS_CLK_KHZ       200000 // Master clock rate in kHz
`define LMS_QUAL_SHORT_MS 40     // Qualification time, automatic switching off
`define LMS_QUAL_LONG_MS  5100   // Qualification time, automatic switching on (5.1 s)
`define LMS_QUAL_W        30     // Width of the qualification counters
`define LMS_TRANSMIT_CLOCK_INPUT_LIMIT    7'h46  // Quiet cycles tolerated on the transmit clock (70)
`define LMS_IDLE_W        7      // Width of the quiet-cycle counter

`endif

/* design/lms_pkg.sv */
// Types shared by the line status block
`include "lms_regs.svh"

package lms_pkg;

  // -------------------------------------------------------------------------
  // Whole state of the block, registered by one process
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                        transmit_clock_input_sync;   // Two-stage pin synchroniser
    logic                              transmit_clock_input_last;   // Previous synchronised level
    logic [`LMS_IDLE_W-1:0]            idle_cnt;    // Cycles since last pin transition
    logic [1:0][`LMS_QUAL_W-1:0]       qual_cnt;    // Code qualification counters
    logic [`LMS_NUM_BITS-1:0]          status;      // Live status bits
    logic [`LMS_NUM_BITS-1:0]          sticky;      // Latched interrupt events
    logic [`LMS_NUM_BITS-1:0]          mask;        // Interrupt masks
    logic [`LMS_NUM_BITS-1:0]          any_edge;    // Edge select bits
    logic                              auto_loop;   // Automatic remote loop switching
    logic                              remote_loop; // Remote loopback running
    logic                              irq;         // Interrupt output
    logic [`LMS_DATA_W-1:0]            rd_data;     // Read data for the port
  } lms_state_type;

endpackage : lms_pkg

/* tb/tb.sv */
// Self-checking testbench of the line maintenance status bits block
`timescale 1ns/1ps
`include "lms_regs.svh"

// ---------------------------------------------------------------------------
// Compare macro, counts every compare and reports a mismatch at once
// ---------------------------------------------------------------------------
`define check(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("[FAIL] t=%0t got %h expected %h", $time, (got), (exp)); \
    end \
  end

module tb;

  // -------------------------------------------------------------------------
  // Short qualification limits keep the run brief
  // -------------------------------------------------------------------------
  localparam int unsigned SHORT_Q = 20; // Limit with automatic switching off
  localparam int unsigned LONG_Q  = 50; // Limit with automatic switching on

  logic                   sys_clk     = 1'b0; // Master clock
  logic                   sys_rst     = 1'b1; // Reset, held at start
  logic [`LMS_ADDR_W-1:0] reg_addr    = '0;   // Register address
  logic [`LMS_DATA_W-1:0] reg_wr_data = '0;   // Write data
  logic                   reg_wr_en   = 1'b0; // Write strobe
  logic                   reg_rd_en   = 1'b0; // Read strobe
  logic [`LMS_DATA_W-1:0] reg_rd_data;        // Read data
  logic                   up_seen     = 1'b0; // Loop-up code present
  logic                   up_ok       = 1'b0; // Loop-up error rate fine
  logic                   down_seen   = 1'b0; // Loop-down code present
  logic                   down_ok     = 1'b0; // Loop-down error rate fine
  logic                   pattern_sync = 1'b0; // Test pattern lock
  logic                   tx_pin      = 1'b0; // Transmit clock pin
  logic                   tx_run      = 1'b1; // Pin toggles while high
  logic                   remote_loop_active; // Remote loopback running
  logic                   irq;                // Interrupt output
  int                     fails       = 0;    // Mismatches seen
  int                     n_compared  = 0;    // Compares made

  // Half period of 2.5 ns gives 200 MHz
  always #2.5 sys_clk = ~sys_clk;

  // Transmit clock pin toggles each cycle unless a test silences it
  always @(posedge sys_clk)
  begin
    if (tx_run)
    begin
      tx_pin <= ~tx_pin;
    end
  end

  lms_status #(
    .SHORT_QUAL_CYCLES (SHORT_Q),
    .LONG_QUAL_CYCLES  (LONG_Q)
  ) i_lms_status (
    .sys_clk              (sys_clk),
    .sys_rst              (sys_rst),
    .reg_addr             (reg_addr),
    .reg_wr_data          (reg_wr_data),
    .reg_wr_en            (reg_wr_en),
    .reg_rd_en            (reg_rd_en),
    .reg_rd_data          (reg_rd_data),
    .loop_up_code_seen    (up_seen),
    .loop_up_ber_ok       (up_ok),
    .loop_down_code_seen  (down_seen),
    .loop_down_ber_ok     (down_ok),
    .pattern_sync         (pattern_sync),
    .transmit_clock_input (tx_pin),
    .remote_loop_active   (remote_loop_active),
    .irq                  (irq)
  );

  // -------------------------------------------------------------------------
  // Bus helpers: one-cycle strobes, read data checked in the following cycle
  // -------------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr_en   <= 1'b1;
    @(posedge sys_clk);
    reg_wr_en   <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    #1;
    `check(reg_rd_data, exp)
  endtask : rd_chk

  // -------------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------------
  task automatic t_reset;
    rd_chk(3'h2, 8'h78);
    rd_chk(3'h3, 8'h00);
    rd_chk(3'h4, 8'h00);
    rd_chk(3'h0, 8'h00);
    wr(3'h0, 8'hff);       // Live status is read only
    wr(3'h6, 8'hff);       // Unmapped place swallows the write
    rd_chk(3'h0, 8'h00);
    rd_chk(3'h6, 8'h00);
    `check({irq, remote_loop_active}, 2'b00)
    $display("test reset done");
  endtask : t_reset

  task automatic t_loop_up;
    wr(3'h2, 8'h38);
    @(posedge sys_clk);
    up_seen <= 1'b1;
    up_ok   <= 1'b1;
    cyc(10);
    up_ok <= 1'b0;         // A break restarts the qualification
    cyc(1);
    up_ok <= 1'b1;
    cyc(SHORT_Q);
    `check(remote_loop_active, 1'b0)
    cyc(1);
    `check({remote_loop_active, irq}, 2'b11)
    rd_chk(3'h0, 8'h40);
    rd_chk(3'h1, 8'h40);
    cyc(1);
    `check(irq, 1'b0)
    up_seen <= 1'b0;
    cyc(3);
    rd_chk(3'h0, 8'h40);
    up_ok <= 1'b0;
    cyc(3);
    rd_chk(3'h0, 8'h00);
    `check(irq, 1'b0)
    $display("test loop up done");
  endtask : t_loop_up

  task automatic t_loop_down;
    wr(3'h4, 8'h01);
    wr(3'h2, 8'h58);
    wr(3'h3, 8'h20);
    @(posedge sys_clk);
    down_seen <= 1'b1;
    down_ok   <= 1'b1;
    cyc(LONG_Q);
    `check({remote_loop_active, irq}, 2'b10)
    cyc(1);
    `check({remote_loop_active, irq}, 2'b01)
    rd_chk(3'h0, 8'h20);
    rd_chk(3'h1, 8'h20);
    down_ok <= 1'b0;
    cyc(3);
    `check(irq, 1'b1)
    rd_chk(3'h1, 8'h20);
    down_seen <= 1'b0;
    wr(3'h4, 8'h00);
    $display("test loop down done");
  endtask : t_loop_down

  task automatic t_pattern;
    wr(3'h2, 8'h78);
    wr(3'h3, 8'h00);
    @(posedge sys_clk);
    pattern_sync <= 1'b1;
    cyc(2);
    rd_chk(3'h0, 8'h10);
    `check(irq, 1'b0)
    wr(3'h1, 8'h00);
    rd_chk(3'h4, 8'h00);
    @(posedge sys_clk);
    reg_addr  <= 3'h1;
    reg_rd_en <= 1'b1;     // Discard events latched while masked
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    wr(3'h3, 8'h10);
    wr(3'h2, 8'h68);
    cyc(1);
    `check(irq, 1'b0)
    pattern_sync <= 1'b0;
    cyc(2);
    `check(irq, 1'b1)
    rd_chk(3'h1, 8'h10);
    rd_chk(3'h0, 8'h00);
    $display("test pattern done");
  endtask : t_pattern

  task automatic t_tx_loss;
    wr(3'h2, 8'h70);
    wr(3'h3, 8'h08);
    @(posedge sys_clk);
    tx_run <= 1'b0;
    cyc(60);
    `check(irq, 1'b0)
    cyc(30);
    `check(irq, 1'b1)
    rd_chk(3'h0, 8'h08);
    rd_chk(3'h1, 8'h08);
    tx_run <= 1'b1;
    cyc(6);
    rd_chk(3'h0, 8'h00);
    `check(irq, 1'b1)
    rd_chk(3'h1, 8'h08);
    $display("test tx clock loss done");
  endtask : t_tx_loss

  // -------------------------------------------------------------------------
  // Verdict, the single place where the run ends
  // -------------------------------------------------------------------------
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // Main sequence: reset for 10 cycles, then each scenario in turn
  initial
  begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_loop_up();
    t_loop_down();
    t_pattern();
    t_tx_loss();
    print_verdict();
  end

  // Watchdog, far beyond the few hundred cycles the tests take
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    print_verdict();
  end

endmodule : tb
